// File: hdl/wdt_defines.svh
// constants for the i/o read watchdog timer
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_ADDR_ARM 16'h0443
`define WDT_ADDR_DISARM 16'h0843
`define WDT_ADDR_DISARM_ALT 16'h0043
`define WDT_CLK_PERIOD_NS 8
`define WDT_TICK_NS 1000000
`define WDT_PERIOD_MS_0 1000
`define WDT_PERIOD_MS_1 2000
`define WDT_PERIOD_MS_2 10000
`define WDT_PERIOD_MS_3 20000
`define WDT_PULSE_CYC 8'h10
`define WDT_STAT_ARMED_BIT 0
`define WDT_STAT_FIRED_BIT 1
`define WDT_STAT_ACTION_BIT 2
`endif

// File: hdl/wdt_pkg.sv
// types for the i/o read watchdog timer
package wdt_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_FIRE = 2'h3
  } wdt_state_t;
endpackage

// File: hdl/io_read_watchdog_timer.sv
// watchdog armed, refreshed and disarmed by host i/o port reads
`timescale 1ns/10ps
`include "wdt_defines.svh"

// Behaviour
// (R01) reading the arm port arms the watchdog and starts the countdown
// (R02) each further arm-port read while armed reloads the full period
// (R03) reading either disarm port stops the countdown and disarms
// (R04) on expiry assert cold reset or nmi, chosen by action select
// (R05) countdown length comes from the static period select input
// (R06) host must refresh within seventy percent of the period
// (R07) host must disarm before the servicing program ends
// (R08) comes up disarmed after reset; writes to either port do nothing
module io_read_watchdog_timer #(
  parameter int TICK_CYC = `WDT_TICK_NS / `WDT_CLK_PERIOD_NS,
  parameter int PERIOD_MS_0 = `WDT_PERIOD_MS_0,
  parameter int PERIOD_MS_1 = `WDT_PERIOD_MS_1,
  parameter int PERIOD_MS_2 = `WDT_PERIOD_MS_2,
  parameter int PERIOD_MS_3 = `WDT_PERIOD_MS_3,
  parameter int PRE_W = 17,
  parameter int MS_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic timeout_action_select,
  input wire logic [1:0] timeout_period_select,
  output logic [7:0] io_data_out,
  output logic io_data_oe,
  output logic cold_reset,
  output logic nmi
);

  // refuse parameters the counters cannot hold
  if (TICK_CYC < 1 || TICK_CYC >= (1 << PRE_W)) begin : g_bad_tick
    $error("tick count does not fit the prescaler");
  end
  if (PERIOD_MS_0 < 1 || PERIOD_MS_0 >= (1 << MS_W) ||
      PERIOD_MS_1 < 1 || PERIOD_MS_1 >= (1 << MS_W) ||
      PERIOD_MS_2 < 1 || PERIOD_MS_2 >= (1 << MS_W) ||
      PERIOD_MS_3 < 1 || PERIOD_MS_3 >= (1 << MS_W)) begin : g_bad_period
    $error("period does not fit the countdown");
  end

  typedef struct packed {
    logic [15:0] addr_s1;
    logic [15:0] addr_s2;
    logic rd_s1;
    logic rd_s2;
    logic rd_s3;
    logic act_s1;
    logic act_s2;
    logic [1:0] per_s1;
    logic [1:0] per_s2;
    wdt_pkg::wdt_state_t st;
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] ms;
    logic [7:0] pulse;
    logic fired;
    logic [7:0] rdata;
    logic oe;
  } wdt_regs_t;

  wdt_regs_t s_r;
  wdt_regs_t s_nxt;

  logic rd_start;
  logic hit_arm;
  logic hit_disarm;
  logic tick;
  logic [MS_W-1:0] period_ms;

  // falling edge of the synchronised read strobe
  assign rd_start = s_r.rd_s3 & ~s_r.rd_s2;
  assign hit_arm = s_r.addr_s2 == `WDT_ADDR_ARM;
  assign hit_disarm = s_r.addr_s2 == `WDT_ADDR_DISARM ||
                      s_r.addr_s2 == `WDT_ADDR_DISARM_ALT;
  assign tick = s_r.pre == PRE_W'(TICK_CYC - 1);

  always_comb begin
    case (s_r.per_s2)
      2'h0: period_ms = MS_W'(PERIOD_MS_0); // see (R05)
      2'h1: period_ms = MS_W'(PERIOD_MS_1);
      2'h2: period_ms = MS_W'(PERIOD_MS_2);
      default: period_ms = MS_W'(PERIOD_MS_3);
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.addr_s1 = io_addr;
    s_nxt.addr_s2 = s_r.addr_s1;
    s_nxt.rd_s1 = io_rd_n;
    s_nxt.rd_s2 = s_r.rd_s1;
    s_nxt.rd_s3 = s_r.rd_s2;
    s_nxt.act_s1 = timeout_action_select;
    s_nxt.act_s2 = s_r.act_s1;
    s_nxt.per_s1 = timeout_period_select;
    s_nxt.per_s2 = s_r.per_s1;
    // write strobe is never looked at: writes do nothing, see (R08)
    s_nxt.oe = ~s_r.rd_s2 & (hit_arm | hit_disarm);
    if (rd_start) begin
      s_nxt.rdata = 8'h00;
      s_nxt.rdata[`WDT_STAT_ARMED_BIT] = s_r.st == wdt_pkg::ST_ARMED;
      s_nxt.rdata[`WDT_STAT_FIRED_BIT] = s_r.fired;
      s_nxt.rdata[`WDT_STAT_ACTION_BIT] = s_r.act_s2;
    end
    case (s_r.st)
      wdt_pkg::ST_IDLE: begin
        if (rd_start && hit_arm) begin
          s_nxt.st = wdt_pkg::ST_ARMED; // see (R01)
          s_nxt.pre = '0;
          s_nxt.ms = period_ms; // see (R05)
          s_nxt.fired = 1'b0;
        end
      end
      wdt_pkg::ST_ARMED: begin
        if (rd_start && hit_disarm) begin
          s_nxt.st = wdt_pkg::ST_IDLE; // see (R03)
        end else if (rd_start && hit_arm) begin
          s_nxt.pre = '0; // see (R02)
          s_nxt.ms = period_ms;
        end else if (tick) begin
          s_nxt.pre = '0;
          if (s_r.ms == '0) begin
            s_nxt.st = wdt_pkg::ST_FIRE; // see (R04)
            s_nxt.pulse = `WDT_PULSE_CYC;
            s_nxt.fired = 1'b1;
          end else begin
            s_nxt.ms = s_r.ms - MS_W'(1); // see (R01)
          end
        end else begin
          s_nxt.pre = s_r.pre + PRE_W'(1);
        end
      end
      wdt_pkg::ST_FIRE: begin
        // pulse runs out, then back to disarmed
        if (s_r.pulse == 8'h01)
          s_nxt.st = wdt_pkg::ST_IDLE;
        s_nxt.pulse = s_r.pulse - 8'h01;
      end
      default: s_nxt.st = wdt_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.rd_s1 <= 1'b1;
      s_r.rd_s2 <= 1'b1;
      s_r.rd_s3 <= 1'b1;
      s_r.st <= wdt_pkg::ST_IDLE; // see (R08)
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign io_data_out = s_r.rdata;
  assign io_data_oe = s_r.oe;
  // action select picks the expiry output, see (R04)
  assign cold_reset = s_r.st == wdt_pkg::ST_FIRE && s_r.act_s2;
  assign nmi = s_r.st == wdt_pkg::ST_FIRE && !s_r.act_s2;

  sequence s_arm_read;
    ce && rd_start && hit_arm;
  endsequence

  sequence s_expire;
    ce && s_r.st == wdt_pkg::ST_ARMED && tick && s_r.ms == '0 &&
      !(rd_start && (hit_arm || hit_disarm));
  endsequence

  property p_arm;
    @(posedge clk_sys) disable iff (rst)
      s_arm_read and (s_r.st == wdt_pkg::ST_IDLE) |=>
        s_r.st == wdt_pkg::ST_ARMED && s_r.ms == $past(period_ms);
  endproperty
  a_arm: assert property (p_arm) else $error("arm read did not arm"); // see (R01)

  property p_refresh;
    @(posedge clk_sys) disable iff (rst)
      s_arm_read and (s_r.st == wdt_pkg::ST_ARMED) |=>
        s_r.ms == $past(period_ms) && s_r.pre == '0;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh no reload"); // see (R02)

  property p_disarm;
    @(posedge clk_sys) disable iff (rst)
      ce && rd_start && hit_disarm && s_r.st == wdt_pkg::ST_ARMED |=>
        s_r.st == wdt_pkg::ST_IDLE ##1 !cold_reset && !nmi;
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm ignored"); // see (R03)

  property p_fire_reset;
    @(posedge clk_sys) disable iff (rst)
      s_expire and s_r.act_s2 |=> cold_reset && !nmi;
  endproperty
  a_fire_reset: assert property (p_fire_reset) else $error("no reset"); // see (R04)

  property p_fire_nmi;
    @(posedge clk_sys) disable iff (rst)
      s_expire and !s_r.act_s2 |=> nmi && !cold_reset;
  endproperty
  a_fire_nmi: assert property (p_fire_nmi) else $error("no nmi"); // see (R04)

  property p_count_down;
    @(posedge clk_sys) disable iff (rst)
      ce && s_r.st == wdt_pkg::ST_ARMED && tick && s_r.ms != '0 && !rd_start
        |=> s_r.ms == $past(s_r.ms) - MS_W'(1);
  endproperty
  a_count_down: assert property (p_count_down) else $error("bad count"); // see (R05)

  property p_reset_idle;
    @(posedge clk_sys) rst |=> s_r.st == wdt_pkg::ST_IDLE && !cold_reset
      && !nmi;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle"); // see (R08)

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (rst)
      s_r.st == wdt_pkg::ST_IDLE && !(rd_start && hit_arm) |=>
        s_r.st == wdt_pkg::ST_IDLE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("armed alone"); // see (R08)

endmodule

// File: verif/host_io_model.sv
// host cpu model issuing i/o port reads and writes
`timescale 1ns/10ps
module host_io_model (
  input wire logic clk_sys,
  output logic [15:0] io_addr,
  output logic io_rd_n,
  output logic io_wr_n
);
  initial begin
    io_addr = 16'h0000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
  end
  // addr set 2 cycles early, strobe 3 low then 3 high
  task automatic access(input logic [15:0] a, input logic wr);
    @(posedge clk_sys);
    io_addr <= a;
    repeat (2) @(posedge clk_sys);
    if (wr)
      io_wr_n <= 1'b0;
    else
      io_rd_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    io_rd_n <= 1'b1;
    io_wr_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    io_addr <= ~a;
  endtask
  // refresh well inside the period, then disarm
  task automatic service(input int cnt, input logic [15:0] off);
    repeat (cnt) access(16'h0443, 1'b0);
    access(off, 1'b0);
  endtask
endmodule

// File: verif/io_read_watchdog_timer_tb_top.sv
// self-checking bench for the i/o read watchdog timer
`timescale 1ns/10ps
module io_read_watchdog_timer_tb_top;
  logic clk_sys, rst, ce, act_sel, io_rd_n, io_wr_n, io_data_oe;
  logic cold_reset, nmi;
  logic [1:0] per_sel;
  logic [15:0] io_addr;
  logic [7:0] io_data_out;
  int fails, compares, cyc, n, fires, f0, k, oes, o0;
  // rd: status read by the arm access, bit2 action, bit1 fired
  typedef struct {logic [1:0] per; logic act; int due;
    logic [7:0] rd;} row_t;
  row_t rows[4] = '{'{2'h0, 1'b1, 16, 8'h04}, '{2'h1, 1'b0, 24, 8'h02},
    '{2'h2, 1'b1, 32, 8'h06}, '{2'h3, 1'b0, 40, 8'h02}};
  host_io_model host (.clk_sys(clk_sys), .io_addr(io_addr),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n));
  io_read_watchdog_timer #(.TICK_CYC(4), .PERIOD_MS_0(3), .PERIOD_MS_1(5),
    .PERIOD_MS_2(7), .PERIOD_MS_3(9)) DUT (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .io_addr(io_addr), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .timeout_action_select(act_sel), .timeout_period_select(per_sel),
    .io_data_out(io_data_out), .io_data_oe(io_data_oe),
    .cold_reset(cold_reset), .nmi(nmi));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n <= (io_rd_n === 1'b0) ? 0 : n + 1;
    fires <= fires + int'((cold_reset | nmi) === 1'b1);
    oes <= oes + int'(io_data_oe === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic quiet(input string what);
    f0 = fires;
    repeat (60) @(posedge clk_sys);
    check(what, fires - f0, 0);
  endtask
  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {rst, ce, act_sel, per_sel} = 5'h1C;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      per_sel <= rows[i].per;
      act_sel <= rows[i].act;
      repeat (4) @(posedge clk_sys);
      o0 = oes;
      host.access(16'h0443, 1'b0);
      @(negedge clk_sys);
      check("oe_len", oes - o0, 3);
      check("status", io_data_out, rows[i].rd);
      for (k = 0; k < 200 && (cold_reset | nmi) !== 1'b1; k++)
        @(negedge clk_sys);
      check("fire_time", n >= rows[i].due - 2 && n <= rows[i].due + 4, 1);
      check("cold_reset", cold_reset, rows[i].act);
      check("nmi", nmi, !rows[i].act);
      repeat (30) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("outs_reset", {io_data_oe, cold_reset, nmi}, 3'h0);
    quiet("idle");
    o0 = oes;
    host.access(16'h0443, 1'b1);
    quiet("write");
    check("write_oe", oes - o0, 0);
    f0 = fires;
    host.service(8, 16'h0843);
    @(negedge clk_sys);
    check("refresh", fires - f0, 0);
    check("disarm_data", io_data_out, 8'h01);
    quiet("disarm");
    host.service(1, 16'h0043);
    @(negedge clk_sys);
    check("disarm_alt_data", io_data_out, 8'h01);
    quiet("disarm_alt");
    // armed count must hold while ce is low, then run on
    host.access(16'h0443, 1'b0);
    ce <= 1'b0;
    quiet("frozen");
    ce <= 1'b1;
    f0 = fires;
    repeat (60) @(posedge clk_sys);
    check("thawed", fires - f0 > 0, 1);
    give_verdict();
  end
endmodule
